//--- rtl/lrc_pkg.sv
// Shared constants and types for the low-rate conversion sequencer and its host end
package lrc_pkg;
  localparam int unsigned   CLK_HZ          = 10_000_000;
  localparam int unsigned   PWRUP_TIME_US   = 100;
  localparam int unsigned   PWRUP_CYCLES    = (PWRUP_TIME_US * (CLK_HZ / 1_000_000));
  localparam logic [7:0]    SEQ_CTRL_ADDR   = 8'h42;
  localparam logic [15:0]   SEQ_CTRL_RESET  = 16'h0000;
  localparam int unsigned   SEQ_LSB         = 0;
  localparam int unsigned   SEQ_W           = 2;
  localparam int unsigned   NUM_CH          = 4;
  localparam int unsigned   NUM_DIAG        = 4;
  localparam int unsigned   CONV_CYCLES     = 16;
  // Host-side register offsets
  localparam logic [3:0]    HOST_CMD_OFS    = 4'h0;
  localparam logic [3:0]    HOST_STAT_OFS   = 4'h4;
  localparam logic [3:0]    HOST_SEQ_OFS    = 4'h8;
  // Sequence codes
  typedef enum logic [1:0] {
    LRC_SEQ_IDLE   = 2'h0,
    LRC_SEQ_SINGLE = 2'h1,
    LRC_SEQ_CONT   = 2'h2,
    LRC_SEQ_PDOWN  = 2'h3
  } lrc_seq_t;
endpackage

//--- rtl/lrc_if.sv
// Register link between host controller and conversion sequencer
`timescale 1ns/1ps
interface lrc_if;
  import lrc_pkg::*;
  logic [7:0]  addr;   // Register address
  logic [15:0] wdata;  // Write data
  logic        wr;     // Write strobe
  logic        rd;     // Read strobe
  logic [15:0] rdata;  // Read data, cycle after rd
  logic        busy;   // Live busy flag
  modport dev  (input addr, wdata, wr, rd, output rdata, busy);
  modport host (output addr, wdata, wr, rd, input rdata, busy);
endinterface

//--- rtl/lrc_seq_ctrl.sv
// Device end: low-rate conversion sequence control and power-up timing
`timescale 1ns/1ps
module lrc_seq_ctrl
  import lrc_pkg::*;
#(
  parameter int unsigned PWRUP_CNT = PWRUP_CYCLES,
  parameter int unsigned CONV_CNT  = CONV_CYCLES
) (
  input  wire logic                clk_i,        // 10 MHz clock
  input  wire logic                reset_i,      // Async reset, active high
  lrc_if.dev                       bus,          // Register link
  input  wire logic [NUM_CH-1:0]   ch_en_i,      // Channel A..D enables
  input  wire logic [NUM_DIAG-1:0] diag_en_i,    // Diagnostic enables
  output logic                     powered_o,    // Converter powered
  output logic                     conv_start_o, // One-cycle conversion start
  output logic [2:0]               conv_sel_o,   // Slot: 0..3 channel, 4..7 diag
  output logic                     conv_diag_o   // Slot is a diagnostic
);
  localparam int unsigned NSLOT = NUM_CH + NUM_DIAG;

  // One-hot states; down and power-up are kept apart so busy
  // covers only the power-up stretch and not the powered-down time
  typedef enum logic [4:0] {
    ST_DOWN  = 5'h01,
    ST_PWRUP = 5'h02,
    ST_IDLE  = 5'h04,
    ST_CONV  = 5'h08,
    ST_NEXT  = 5'h10
  } lrc_state_t;

  lrc_state_t       state_reg;
  lrc_seq_t         seq_reg;
  logic [15:0]      pwr_cnt_reg;
  logic [15:0]      conv_cnt_reg;
  logic [2:0]       slot_reg;
  logic [NSLOT-1:0] en_lat_reg;
  logic             cont_reg;
  logic             wr_seq;
  logic [NSLOT-1:0] live_en;
  logic [NSLOT-1:0] en_use;
  logic [2:0]       next_slot;
  logic             next_found;
  logic [2:0]       first_slot;
  logic             first_found;
  logic             stop_wr;

  assign wr_seq  = bus.wr && (bus.addr == SEQ_CTRL_ADDR);
  assign live_en = {diag_en_i, ch_en_i};
  // Idle or power-down write; cuts a start pulse launched in the same cycle
  assign stop_wr = wr_seq && (bus.wdata[1:0] == LRC_SEQ_IDLE ||
                              bus.wdata[1:0] == LRC_SEQ_PDOWN);
  // Enables latched at start so a running sequence cannot be altered
  assign en_use  = (state_reg == ST_IDLE) ? live_en : en_lat_reg;

  // Slot search: first enabled slot, and next enabled above current
  // Walks from the top so the last hit is the lowest slot; a priority
  // encoder costs less than a rotating mask here
  always_comb begin
    first_found = 1'b0;
    first_slot  = 3'h0;
    next_found  = 1'b0;
    next_slot   = 3'h0;
    for (int i = NSLOT - 1; i >= 0; i--) begin
      if (en_use[i]) begin
        first_found = 1'b1;
        first_slot  = 3'(i);
        if (3'(i) > slot_reg) begin
          next_found = 1'b1;
          next_slot  = 3'(i);
        end
      end
    end
  end

  // Sequence field; only bits 1:0 stored
  // Field is never cleared by hardware, so a finished pass leaves 01
  // in place and software must write it again for the next pass
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      seq_reg <= lrc_seq_t'(SEQ_CTRL_RESET[SEQ_LSB +: SEQ_W]);
    end else if (wr_seq) begin
      seq_reg <= lrc_seq_t'(bus.wdata[SEQ_LSB +: SEQ_W]);
    end
  end

  // Main control: power state and conversion walk
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_reg    <= ST_DOWN;
      pwr_cnt_reg  <= 16'h0000;
      conv_cnt_reg <= 16'h0000;
      slot_reg     <= 3'h0;
      en_lat_reg   <= '0;
      cont_reg     <= 1'b0;
    end else if (wr_seq && bus.wdata[1:0] == LRC_SEQ_PDOWN) begin
      state_reg <= ST_DOWN;
      cont_reg  <= 1'b0;
    end else if (wr_seq && state_reg == ST_DOWN &&
                 (bus.wdata[1:0] == LRC_SEQ_IDLE || bus.wdata[1:0] == LRC_SEQ_SINGLE)) begin
      // Power-up only; a single-pass code must be rewritten afterwards
      state_reg   <= ST_PWRUP;
      pwr_cnt_reg <= 16'(PWRUP_CNT);
    end else if (wr_seq && bus.wdata[1:0] == LRC_SEQ_IDLE) begin
      if (state_reg != ST_PWRUP) begin
        state_reg <= ST_IDLE;
      end
      cont_reg <= 1'b0;
    end else if (wr_seq && state_reg == ST_IDLE && first_found &&
                 (bus.wdata[1:0] == LRC_SEQ_SINGLE || bus.wdata[1:0] == LRC_SEQ_CONT)) begin
      state_reg    <= ST_CONV;
      en_lat_reg   <= live_en;
      slot_reg     <= first_slot;
      conv_cnt_reg <= 16'(CONV_CNT);
      cont_reg     <= (bus.wdata[1:0] == LRC_SEQ_CONT);
    end else begin
      unique case (state_reg)
        ST_DOWN: begin
          state_reg <= ST_DOWN;
        end
        ST_PWRUP: begin
          // Counter runs out after PWRUP_CNT cycles; busy stays high
          // for exactly that many cycles after the power-up write
          if (pwr_cnt_reg <= 16'h0001) begin
            state_reg <= ST_IDLE;
          end
          pwr_cnt_reg <= pwr_cnt_reg - 16'h0001;
        end
        ST_IDLE: begin
          state_reg <= ST_IDLE;
        end
        ST_CONV: begin
          if (conv_cnt_reg <= 16'h0001) begin
            state_reg <= ST_NEXT;
          end
          conv_cnt_reg <= conv_cnt_reg - 16'h0001;
        end
        ST_NEXT: begin
          // One spare cycle per slot keeps starts apart by CONV_CNT+1
          // and gives the slot search a settled slot number
          conv_cnt_reg <= 16'(CONV_CNT);
          if (next_found) begin
            slot_reg  <= next_slot;
            state_reg <= ST_CONV;
          end else if (cont_reg) begin
            slot_reg  <= first_slot;
            state_reg <= ST_CONV;
          end else begin
            state_reg <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // Read port: field in low bits, reserved bits zero
  // Data stands from the cycle after the read strobe until the next one;
  // any other address reads zero rather than holding stale data
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      bus.rdata <= 16'h0000;
    end else if (bus.rd) begin
      bus.rdata <= (bus.addr == SEQ_CTRL_ADDR) ? {14'h0000, seq_reg} : 16'h0000;
    end
  end

  // Busy covers power-up and any running pass
  // Combinational so it drops in the same cycle the walk returns to idle
  assign bus.busy = (state_reg == ST_PWRUP) || (state_reg == ST_CONV) ||
                    (state_reg == ST_NEXT);
  assign powered_o = (state_reg != ST_DOWN);

  // Conversion start pulses in the cycle after the first cycle of each slot
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      conv_start_o <= 1'b0;
      conv_sel_o   <= 3'h0;
      conv_diag_o  <= 1'b0;
    end else begin
      // A stop written in this cycle wins over a slot that would start now
      conv_start_o <= (state_reg == ST_CONV) && (conv_cnt_reg == 16'(CONV_CNT)) &&
                      !stop_wr;
      conv_sel_o   <= slot_reg;
      conv_diag_o  <= (slot_reg >= 3'(NUM_CH));
    end
  end
endmodule // lrc_seq_ctrl

//--- rtl/lrc_host.sv
// Host end: drives sequence codes with the required ordering and waits
`timescale 1ns/1ps
module lrc_host
  import lrc_pkg::*;
(
  input  wire logic        clk_i,     // 10 MHz clock
  input  wire logic        reset_i,   // Async reset, active high
  lrc_if.host              bus,       // Register link
  input  wire logic [3:0]  sw_addr_i, // Software address
  input  wire logic [15:0] sw_wdata_i,// Software write data
  input  wire logic        sw_wr_i,   // Software write strobe
  input  wire logic        sw_rd_i,   // Software read strobe
  output logic      [15:0] sw_rdata_o // Software read data
);
  typedef enum logic [3:0] {
    HS_IDLE = 4'h1,
    HS_PRE  = 4'h2,
    HS_WAIT = 4'h4,
    HS_GO   = 4'h8
  } lrc_hstate_t;

  lrc_hstate_t hs_reg;
  lrc_seq_t    cmd_reg;
  lrc_seq_t    last_reg;
  logic        done_reg;
  logic        err_reg;
  logic        pending_reg;
  logic [15:0] seq_rd_reg;
  logic        rd_dly_reg;
  logic        cmd_wr;

  assign cmd_wr = sw_wr_i && (sw_addr_i == HOST_CMD_OFS);

  // Command sequencer: idle first when going from continuous to single, then wait busy clear
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      hs_reg      <= HS_IDLE;
      cmd_reg     <= LRC_SEQ_IDLE;
      last_reg    <= LRC_SEQ_PDOWN;
      done_reg    <= 1'b0;
      err_reg     <= 1'b0;
      pending_reg <= 1'b0;
      bus.addr    <= 8'h00;
      bus.wdata   <= 16'h0000;
      bus.wr      <= 1'b0;
    end else begin
      bus.wr <= 1'b0;
      unique case (hs_reg)
        HS_IDLE: begin
          if (cmd_wr) begin
            cmd_reg     <= lrc_seq_t'(sw_wdata_i[1:0]);
            pending_reg <= 1'b1;
            done_reg    <= 1'b0;
            err_reg     <= 1'b0;
            if (last_reg == LRC_SEQ_CONT && sw_wdata_i[1:0] == LRC_SEQ_SINGLE) begin
              hs_reg <= HS_PRE;
            end else begin
              hs_reg <= HS_WAIT;
            end
          end
        end
        HS_PRE: begin
          bus.addr  <= SEQ_CTRL_ADDR;
          bus.wdata <= 16'h0000;
          bus.wr    <= 1'b1;
          last_reg  <= LRC_SEQ_IDLE;
          hs_reg    <= HS_WAIT;
        end
        HS_WAIT: begin
          // Starts other than continuous after continuous wait for busy clear, covering power-up time too
          if (!bus.busy || cmd_reg == LRC_SEQ_PDOWN || cmd_reg == LRC_SEQ_IDLE ||
              (cmd_reg == LRC_SEQ_CONT && last_reg == LRC_SEQ_CONT)) begin
            hs_reg <= HS_GO;
          end
        end
        HS_GO: begin
          // From power-down a single code would only power up and a continuous code would be ignored; flag both instead
          if (last_reg == LRC_SEQ_PDOWN &&
              (cmd_reg == LRC_SEQ_SINGLE || cmd_reg == LRC_SEQ_CONT)) begin
            err_reg <= 1'b1;
          end else begin
            bus.addr  <= SEQ_CTRL_ADDR;
            bus.wdata <= {14'h0000, cmd_reg};
            bus.wr    <= 1'b1;
            last_reg  <= cmd_reg;
          end
          pending_reg <= 1'b0;
          done_reg    <= 1'b1;
          hs_reg      <= HS_IDLE;
        end
      endcase
    end
  end

  // Reads of the device field pass through; data taken the cycle after rd
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      bus.rd     <= 1'b0;
      rd_dly_reg <= 1'b0;
      seq_rd_reg <= 16'h0000;
    end else begin
      bus.rd     <= sw_rd_i && (sw_addr_i == HOST_SEQ_OFS);
      rd_dly_reg <= bus.rd;
      if (rd_dly_reg) begin
        seq_rd_reg <= bus.rdata;
      end
    end
  end

  // Software read data, one cycle after strobe
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      sw_rdata_o <= 16'h0000;
    end else if (sw_rd_i) begin
      unique case (sw_addr_i)
        HOST_CMD_OFS:  sw_rdata_o <= {14'h0000, cmd_reg};
        HOST_STAT_OFS: sw_rdata_o <= {10'h000, last_reg, err_reg, done_reg,
                                      pending_reg, bus.busy};
        HOST_SEQ_OFS:  sw_rdata_o <= seq_rd_reg;
        default:       sw_rdata_o <= 16'h0000;
      endcase
    end
  end
endmodule // lrc_host

//--- testbench/lrc_properties.sv
// Concurrent checks on the sequencer register link and conversion outputs
`timescale 1ns/1ps
module lrc_properties
  import lrc_pkg::*;
#(
  parameter int PWRUP_CNT = 20
) (
  input wire logic        clk_i,        // Clock
  input wire logic        reset_i,      // Async reset
  input wire logic [7:0]  addr,         // Link address
  input wire logic [15:0] wdata,        // Link write data
  input wire logic        wr,           // Write strobe
  input wire logic        rd,           // Read strobe
  input wire logic [15:0] rdata,        // Read data
  input wire logic        busy,         // Busy flag
  input wire logic [3:0]  ch_en_i,      // Channel enables
  input wire logic [3:0]  diag_en_i,    // Diagnostic enables
  input wire logic        powered_o,    // Converter powered
  input wire logic        conv_start_o, // Conversion start
  input wire logic [2:0]  conv_sel_o,   // Slot
  input wire logic        conv_diag_o   // Diagnostic slot
);
  // Margin past the power-up count for the busy fall
  localparam int PW_HI = PWRUP_CNT + 2;
  logic       w42;
  logic [7:0] en_all;
  // Write to the sequence register, and all enables as one slot map
  assign w42 = wr && addr == SEQ_CTRL_ADDR;
  assign en_all = {diag_en_i, ch_en_i};
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  chk_rsvd_zero: assert property (rd |=> rdata[15:2] == 14'h0000)
    else $error("reserved bits read nonzero");
  chk_pwrup_busy: assert property (w42 && wdata[1:0] == 2'h0 && !powered_o && !busy |=> busy[*8])
    else $error("busy low during power-up");
  chk_pwrup_end: assert property (w42 && wdata[1:0] == 2'h0 && !powered_o && !busy |-> ##[1:PW_HI] !busy)
    else $error("power-up did not end");
  chk_pdown_off: assert property (w42 && wdata[1:0] == 2'h3 |-> ##[1:3] !powered_o)
    else $error("power-down code ignored");
  chk_no_conv_off: assert property (!powered_o |-> !conv_start_o)
    else $error("conversion while unpowered");
  chk_slot_enabled: assert property (conv_start_o |-> en_all[conv_sel_o])
    else $error("disabled slot converted");
  chk_diag_flag: assert property (conv_start_o |-> conv_diag_o == conv_sel_o[2])
    else $error("diagnostic flag wrong");
  chk_slot_gap: assert property (conv_start_o |=> !conv_start_o [*3])
    else $error("slots too close");
  chk_conv_busy: assert property (conv_start_o |-> busy)
    else $error("conversion without busy");
  chk_start_busy: assert property (w42 && wdata[1:0] == 2'h1 && powered_o && !busy |=> busy)
    else $error("single pass not started");
  chk_idle_stop: assert property (w42 && wdata[1:0] == 2'h0 && powered_o |-> ##[1:10] !busy)
    else $error("idle code did not stop");
  // Main scenarios reached
  cov_diag: cover property (conv_start_o && conv_diag_o);
  cov_cont: cover property (w42 && wdata[1:0] == 2'h2);
  cov_pdown: cover property ($fell(powered_o));
endmodule // lrc_properties

//--- testbench/lrc_seq_ctrl_test.sv
// Self-checking bench: host end drives the sequencer across the register link
`timescale 1ns/1ps
module lrc_seq_ctrl_test;
  import lrc_pkg::*;
  localparam int PWR_N = 20; // Shortened power-up keeps the run brief
  logic        clk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic [3:0]  sw_addr = 4'h0;
  logic [3:0]  ch_en = 4'h0;
  logic [3:0]  diag_en = 4'h0;
  logic [15:0] sw_wdata = 16'h0000;
  logic        sw_wr = 1'b0;
  logic        sw_rd = 1'b0;
  logic [15:0] sw_rdata;
  logic [15:0] rv;
  logic        powered, conv_start, conv_diag;
  logic [2:0]  conv_sel;
  logic [7:0]  sel_seen = 8'h00;
  int          error_cnt = 0;
  int          n_compared = 0;
  int          n_start = 0;
  int          len;
  lrc_if link ();
  always #50 clk_i = ~clk_i;
  lrc_seq_ctrl #(.PWRUP_CNT(PWR_N), .CONV_CNT(3)) lrc_seq_ctrl_inst (
    .clk_i(clk_i), .reset_i(reset_i), .bus(link.dev), .ch_en_i(ch_en), .diag_en_i(diag_en),
    .powered_o(powered), .conv_start_o(conv_start), .conv_sel_o(conv_sel),
    .conv_diag_o(conv_diag));
  lrc_host lrc_host_inst (
    .clk_i(clk_i), .reset_i(reset_i), .bus(link.host), .sw_addr_i(sw_addr),
    .sw_wdata_i(sw_wdata), .sw_wr_i(sw_wr), .sw_rd_i(sw_rd), .sw_rdata_o(sw_rdata));
  lrc_properties #(.PWRUP_CNT(PWR_N)) lrc_properties_inst (
    .clk_i(clk_i), .reset_i(reset_i), .addr(link.addr), .wdata(link.wdata), .wr(link.wr),
    .rd(link.rd), .rdata(link.rdata), .busy(link.busy), .ch_en_i(ch_en),
    .diag_en_i(diag_en), .powered_o(powered), .conv_start_o(conv_start),
    .conv_sel_o(conv_sel), .conv_diag_o(conv_diag));
  // Tally conversion starts and the slots they used
  always @(posedge clk_i) begin
    if (conv_start === 1'b1) begin
      n_start <= n_start + 1;
      sel_seen <= sel_seen | (8'h01 << conv_sel);
    end
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("compared %0d, errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Clear tallies off the edge, so the tally process never races
  task automatic clear();
    @(negedge clk_i);
    n_start = 0;
    sel_seen = 8'h00;
    @(posedge clk_i);
  endtask
  // One software write strobe on the host port
  task automatic sw_reg_write(input logic [3:0] a, input logic [15:0] d);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge clk_i);
    sw_wr <= 1'b0;
  endtask
  // One software read; data stands the cycle after the strobe
  task automatic sw_read(input logic [3:0] a, output logic [15:0] d);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge clk_i);
    sw_rd <= 1'b0;
    @(posedge clk_i);
    d = sw_rdata;
  endtask
  // Device field: first read fetches over the link, second returns it
  task automatic rd_field(output logic [15:0] d);
    sw_read(HOST_SEQ_OFS, d);
    repeat (2) @(posedge clk_i);
    sw_read(HOST_SEQ_OFS, d);
  endtask
  // Wait for the next link write to the field and check its code
  task automatic wait_link(input lrc_seq_t code);
    int n;
    @(posedge clk_i);
    for (n = 0; n < 300 && !(link.wr === 1'b1 && link.addr === SEQ_CTRL_ADDR); n++)
      @(posedge clk_i);
    check({14'h0000, link.wdata[1:0]}, {14'h0000, code});
  endtask
  // Command one code and wait until the host passes it on
  task automatic sw_write(input lrc_seq_t code);
    sw_reg_write(HOST_CMD_OFS, {14'h0000, code});
    wait_link(code);
  endtask
  // Length of the next busy stretch, bounded
  task automatic busy_len(output int n);
    n = 0;
    repeat (300) begin
      @(posedge clk_i);
      if (link.busy === 1'b1) n++;
      else if (n > 0) break;
    end
  endtask
  initial begin
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    check({15'h0000, powered}, 16'h0000);
    sw_write(LRC_SEQ_IDLE);
    busy_len(len);
    check(16'(len), 16'(PWR_N));
    check({15'h0000, powered}, 16'h0001);
    ch_en <= 4'h5;
    diag_en <= 4'h8;
    // Field stays 01, so each pass needs its own write
    repeat (2) begin
      clear();
      sw_write(LRC_SEQ_SINGLE);
      busy_len(len);
      check(16'(n_start), 16'h0003);
      check({8'h00, sel_seen}, 16'h0085);
    end
    rd_field(rv);
    check(rv, 16'h0001);
    ch_en <= 4'h3;
    diag_en <= 4'h0;
    clear();
    sw_write(LRC_SEQ_CONT);
    repeat (40) @(posedge clk_i);
    ch_en <= 4'hf; // Enables move mid-run and must be ignored
    repeat (40) @(posedge clk_i);
    check({15'h0000, n_start > 10}, 16'h0001);
    check({8'h00, sel_seen}, 16'h0003);
    // Continuous to single: host must put idle in between
    sw_reg_write(HOST_CMD_OFS, {14'h0000, LRC_SEQ_SINGLE});
    wait_link(LRC_SEQ_IDLE);
    clear();
    wait_link(LRC_SEQ_SINGLE);
    busy_len(len);
    check(16'(n_start), 16'h0004);
    check({8'h00, sel_seen}, 16'h000f);
    sw_write(LRC_SEQ_IDLE);
    repeat (10) @(posedge clk_i);
    clear();
    repeat (20) @(posedge clk_i);
    check(16'(n_start), 16'h0000);
    sw_write(LRC_SEQ_PDOWN);
    repeat (3) @(posedge clk_i);
    check({15'h0000, powered}, 16'h0000);
    rd_field(rv);
    check(rv, 16'h0003);
    sw_read(HOST_STAT_OFS, rv);
    check(rv, 16'h0034);
    // Start straight from power-down is refused and flagged
    sw_reg_write(HOST_CMD_OFS, {14'h0000, LRC_SEQ_SINGLE});
    repeat (6) @(posedge clk_i);
    sw_read(HOST_STAT_OFS, rv);
    check(rv, 16'h003c);
    sw_read(HOST_CMD_OFS, rv);
    check(rv, 16'h0001);
    check({15'h0000, powered}, 16'h0000);
    stop_test();
  end
  // Watchdog well past the expected run of about 240 cycles
  initial begin
    #(100 * 6000);
    error_cnt++;
    stop_test();
  end
endmodule // lrc_seq_ctrl_test
